//--- include/pbs_pkg.sv
// Shared constants and carrier types for the pipelined burst memory control.
// Assumes one 20 MHz clock and synchronous inputs; no register bus exists.
package pbs_pkg;

	// Clock rate of the control logic in MHz.
	localparam int unsigned PBS_CLK_MHZ = 20;

	// Array shape: byte lanes of eight data bits plus one parity bit.
	localparam int unsigned PBS_LANES = 4;
	localparam int unsigned PBS_LANE_DW = 8;
	localparam int unsigned PBS_LANE_W = PBS_LANE_DW + 1;
	localparam int unsigned PBS_DATA_DW = PBS_LANES * PBS_LANE_DW;
	localparam int unsigned PBS_PAR_W = PBS_LANES;
	localparam int unsigned PBS_W = PBS_DATA_DW + PBS_PAR_W;
	localparam int unsigned PBS_ADDR_W = 6;
	localparam int unsigned PBS_DEPTH = 1 << PBS_ADDR_W;

	// Burst counter width and the write buffer depth.
	localparam int unsigned PBS_BURST_W = 2;
	localparam int unsigned PBS_FIFO_DEPTH = 32;

	// Burst order strap levels.
	localparam logic PBS_ORDER_LINEAR = 1'b0;
	localparam logic PBS_ORDER_INTERLEAVED = 1'b1;

	// Reset values, the burst step and the lane masks.
	localparam logic [PBS_W-1:0] PBS_DATA_RST = {PBS_W{1'b0}};
	localparam logic [PBS_ADDR_W-1:0] PBS_ADDR_RST = {PBS_ADDR_W{1'b0}};
	localparam logic [PBS_BURST_W-1:0] PBS_BURST_RST = 2'h0;
	localparam logic [PBS_BURST_W-1:0] PBS_BURST_ONE = 2'h1;
	localparam logic [PBS_LANES-1:0] PBS_LANES_ALL = 4'hF;
	localparam logic [PBS_LANES-1:0] PBS_LANES_NONE = 4'h0;

	// Synchronous control pins sampled at each rising edge.
	typedef struct packed {
		logic chip_sel_primary_n;
		logic chip_sel_high_active;
		logic chip_sel_third_n;
		logic processor_addr_strobe_n;
		logic controller_addr_strobe_n;
		logic burst_step_n;
		logic all_bytes_write_n;
		logic byte_write_gate_n;
		logic [PBS_LANES-1:0] byte_lane_select_n;
	} pbs_ctrl_t;

	// One buffered write: target word, lanes to change and the data.
	typedef struct packed {
		logic [PBS_ADDR_W-1:0] addr;
		logic [PBS_LANES-1:0] lanes;
		logic [PBS_W-1:0] data;
	} pbs_wr_t;

	localparam int unsigned PBS_WR_W = $bits(pbs_wr_t);

endpackage

//--- design/pbs_fifo.sv
// Synchronous FIFO built from flip-flops with valid and ready on both sides.
// Assumes a power-of-two depth and a single clock with synchronous reset.
`timescale 1ns/1ns
module pbs_fifo #(
	parameter int unsigned W = 8,
	parameter int unsigned DEPTH = 32
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_srst,
	// Filling side.
	input wire logic i_in_valid,
	input wire logic [W-1:0] i_in_data,
	output logic o_in_ready,
	// Draining side.
	output logic o_out_valid,
	output logic [W-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int unsigned PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
		logic ready;
	} pbs_fifo_st_t;

	pbs_fifo_st_t s_q;
	pbs_fifo_st_t s_d;
	logic push;
	logic pop;

	// Ready is held in a flop so the filler sees an honest full flag.
	assign o_in_ready = s_q.ready;
	assign o_out_valid = (s_q.cnt != '0);
	assign o_out_data = s_q.mem[s_q.rp];
	assign push = i_in_valid && s_q.ready;
	assign pop = o_out_valid && i_out_ready;

	// Next state: store on push, step the read side on pop.
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = i_in_data;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = s_q.rp + 1'b1;
		end
		s_d.cnt = s_q.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
		s_d.ready = (s_d.cnt != FULL);
	end

	// State register.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s_q <= '0;
			s_q.ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

//--- design/pbs_burst_ctr.sv
// Two-bit wraparound burst counter with linear or interleaved order.
// Assumes load and step are never asserted together by the caller.
`timescale 1ns/1ns
module pbs_burst_ctr (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_srst,
	// Control.
	input wire logic i_load,
	input wire logic [pbs_pkg::PBS_BURST_W-1:0] i_start,
	input wire logic i_step,
	input wire logic i_interleave,
	// Burst offsets now and after one step.
	output logic [pbs_pkg::PBS_BURST_W-1:0] o_offset,
	output logic [pbs_pkg::PBS_BURST_W-1:0] o_next
);
	typedef struct packed {
		logic [pbs_pkg::PBS_BURST_W-1:0] start;
		logic [pbs_pkg::PBS_BURST_W-1:0] beat;
	} pbs_ctr_st_t;

	pbs_ctr_st_t s_q;
	pbs_ctr_st_t s_d;
	logic [pbs_pkg::PBS_BURST_W-1:0] beat_nx;

	// Maps a beat count onto an offset in the chosen order.
	function automatic logic [pbs_pkg::PBS_BURST_W-1:0] order_map(
		input logic [pbs_pkg::PBS_BURST_W-1:0] start,
		input logic [pbs_pkg::PBS_BURST_W-1:0] beat,
		input logic inter);
		order_map = inter ? (start ^ beat) : (start + beat);
	endfunction

	assign beat_nx = s_q.beat + pbs_pkg::PBS_BURST_ONE;
	assign o_offset = order_map(s_q.start, s_q.beat, i_interleave);
	assign o_next = order_map(s_q.start, beat_nx, i_interleave);

	// Load takes the start bits; a step moves one beat and wraps at four.
	always_comb begin
		s_d = s_q;
		if (i_load) begin
			s_d.start = i_start;
			s_d.beat = pbs_pkg::PBS_BURST_RST;
		end else if (i_step) begin
			s_d.beat = beat_nx;
		end
	end

	// State register.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

//--- design/pbs_sram_ctrl.sv
// Control core of a pipelined burst memory: selects, strobes, burst
// addressing, pipelined reads, buffered writes and sleep.
// Assumes all inputs are synchronous to i_clk; the data pin wire is
// resolved outside from o_dq, o_dq_oe and the driving party's enable.
`timescale 1ns/1ns

module pbs_sram_ctrl #(
	parameter int unsigned FIFO_DEPTH = pbs_pkg::PBS_FIFO_DEPTH
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_srst,
	// Synchronous bus controls and address.
	input wire pbs_pkg::pbs_ctrl_t i_ctrl,
	input wire logic [pbs_pkg::PBS_ADDR_W-1:0] i_addr,
	// Output enable, active low.
	input wire logic i_out_enable_n,
	// Data and parity pins as input, output and output enable.
	input wire logic [pbs_pkg::PBS_W-1:0] i_dq,
	output logic [pbs_pkg::PBS_W-1:0] o_dq,
	output logic o_dq_oe,
	// Static strap and sleep request.
	input wire logic i_burst_order_strap,
	input wire logic i_sleep_request,
	// Status.
	output logic o_wr_ready,
	output logic o_selected,
	output logic o_sleeping
);
	localparam int unsigned AW = pbs_pkg::PBS_ADDR_W;
	localparam int unsigned BW = pbs_pkg::PBS_BURST_W;
	localparam int unsigned W = pbs_pkg::PBS_W;
	localparam int unsigned LANES = pbs_pkg::PBS_LANES;
	localparam int unsigned LDW = pbs_pkg::PBS_LANE_DW;
	localparam int unsigned DDW = pbs_pkg::PBS_DATA_DW;

	// Whole state of the core, including the storage array.
	typedef struct packed {
		logic [pbs_pkg::PBS_DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] addr;
		logic selected;
		logic sleep;
		logic interleave;
		logic rd_valid;
		logic [W-1:0] rd_data;
		logic [W-1:0] dq;
		logic dq_oe;
	} pbs_core_st_t;

	pbs_core_st_t s_q;
	pbs_core_st_t s_d;

	// Strobe recognition and access decode.
	logic sel_all;
	logic proc_rec;
	logic ctrl_rec;
	logic load;
	logic load_sel;
	logic wr_req;
	logic [LANES-1:0] wr_lanes;
	logic cont;
	logic step;
	logic do_rd;
	logic do_wr;
	logic [AW-1:0] acc_addr;

	// Burst counter offsets.
	logic [BW-1:0] off_now;
	logic [BW-1:0] off_next;

	// Write buffer ports.
	pbs_pkg::pbs_wr_t wr_in;
	pbs_pkg::pbs_wr_t wr_out;
	logic [pbs_pkg::PBS_WR_W-1:0] wr_out_bits;
	logic wr_in_ready;
	logic wr_out_valid;
	logic drain;

	// Lane-wide view of a word: data byte plus its parity bit.
	function automatic logic [pbs_pkg::PBS_LANE_W-1:0] lane_get(
		input logic [W-1:0] word,
		input int unsigned lane);
		lane_get = {word[DDW+lane], word[lane*LDW +: LDW]};
	endfunction

	// Combined select of the three chip selects.
	function automatic logic chip_selected(input pbs_pkg::pbs_ctrl_t c);
		chip_selected = !c.chip_sel_primary_n && c.chip_sel_high_active
			&& !c.chip_sel_third_n;
	endfunction

	// Strobe recognition: the processor strobe needs the primary select
	// and beats the controller strobe on the same edge.
	always_comb begin
		sel_all = chip_selected(i_ctrl);
		proc_rec = !i_ctrl.processor_addr_strobe_n && !i_ctrl.chip_sel_primary_n;
		ctrl_rec = !i_ctrl.controller_addr_strobe_n && !proc_rec;
		load = (proc_rec || ctrl_rec) && !s_q.sleep;
		load_sel = load && sel_all;
		cont = !load && s_q.selected && !s_q.sleep;
		step = cont && !i_ctrl.burst_step_n;
	end

	// Write decode: the all-bytes write takes every lane, otherwise the
	// lane selects count only through the byte gate.
	always_comb begin
		if (!i_ctrl.all_bytes_write_n) begin
			wr_lanes = pbs_pkg::PBS_LANES_ALL;
		end else if (!i_ctrl.byte_write_gate_n) begin
			wr_lanes = ~i_ctrl.byte_lane_select_n;
		end else begin
			wr_lanes = pbs_pkg::PBS_LANES_NONE;
		end
		wr_req = (wr_lanes != pbs_pkg::PBS_LANES_NONE);
	end

	// Access decode. A processor-strobe load ignores write controls on
	// its own edge and starts as a read; a controller-strobe load obeys
	// them at once. Continuation edges use the burst address, stepped
	// first when the burst step is low.
	always_comb begin
		do_rd = 1'b0;
		do_wr = 1'b0;
		acc_addr = s_q.addr;
		if (load_sel) begin
			acc_addr = i_addr;
			if (proc_rec) begin
				do_rd = 1'b1;
			end else begin
				do_rd = !wr_req;
				do_wr = wr_req;
			end
		end else if (cont) begin
			acc_addr = {s_q.addr[AW-1:BW], step ? off_next : off_now};
			do_rd = !wr_req;
			do_wr = wr_req;
		end
	end

	// Write entry captured from the pins at the access edge.
	always_comb begin
		wr_in.addr = acc_addr;
		wr_in.lanes = wr_lanes;
		wr_in.data = i_dq;
	end

	// Buffered writes are drained into the array except during sleep,
	// which stalls the buffer; no new writes enter it while asleep.
	assign wr_out = pbs_pkg::pbs_wr_t'(wr_out_bits);
	assign drain = !s_q.sleep;

	// Burst address generation.
	pbs_burst_ctr u_ctr (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_load(load_sel),
		.i_start(i_addr[BW-1:0]),
		.i_step(step),
		.i_interleave(s_q.interleave),
		.o_offset(off_now),
		.o_next(off_next)
	);

	// Write buffer between the pins and the array.
	pbs_fifo #(
		.W(pbs_pkg::PBS_WR_W),
		.DEPTH(FIFO_DEPTH)
	) u_wbuf (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_in_valid(do_wr),
		.i_in_data(wr_in),
		.o_in_ready(wr_in_ready),
		.o_out_valid(wr_out_valid),
		.o_out_data(wr_out_bits),
		.i_out_ready(drain)
	);

	// Next state of the core.
	always_comb begin
		s_d = s_q;
		// Sleep and strap are sampled each edge; the strap is static.
		s_d.sleep = i_sleep_request;
		s_d.interleave = (i_burst_order_strap == pbs_pkg::PBS_ORDER_INTERLEAVED);
		// A load latches the new select state and, when selected, the address.
		if (load) begin
			s_d.selected = sel_all;
			if (sel_all) begin
				s_d.addr = i_addr;
			end
		end
		if (s_q.sleep) begin
			s_d.selected = 1'b0;
		end
		// The burst address follows each step of the counter.
		if (step) begin
			s_d.addr = {s_q.addr[AW-1:BW], off_next};
		end
		// First pipeline stage: array word at the access address.
		s_d.rd_valid = do_rd;
		s_d.rd_data = s_q.mem[acc_addr];
		// Output register loads the word read on the previous edge.
		if (s_q.rd_valid) begin
			s_d.dq = s_q.rd_data;
		end
		// Pins drive only with a read in flight, a selected device,
		// output enable low, and not on an entry from deselect.
		s_d.dq_oe = s_q.rd_valid && !i_out_enable_n;
		if (i_out_enable_n) begin
			s_d.dq_oe = 1'b0;
		end
		if (load && !s_q.selected) begin
			s_d.dq_oe = 1'b0;
		end
		if (load && !sel_all) begin
			s_d.dq_oe = 1'b0;
		end
		if (s_q.sleep || !s_q.selected) begin
			s_d.dq_oe = s_d.dq_oe && load_sel && s_q.selected;
		end
		// Drained writes change only their selected lanes.
		if (wr_out_valid && drain) begin
			for (int unsigned l = 0; l < LANES; l++) begin
				if (wr_out.lanes[l]) begin
					s_d.mem[wr_out.addr][l*LDW +: LDW] =
						wr_out.data[l*LDW +: LDW];
					s_d.mem[wr_out.addr][DDW+l] = wr_out.data[DDW+l];
				end
			end
		end
	end

	// State register; the array keeps its contents across reset.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s_q.addr <= pbs_pkg::PBS_ADDR_RST;
			s_q.selected <= 1'b0;
			s_q.sleep <= 1'b0;
			s_q.interleave <= pbs_pkg::PBS_ORDER_INTERLEAVED;
			s_q.rd_valid <= 1'b0;
			s_q.rd_data <= pbs_pkg::PBS_DATA_RST;
			s_q.dq <= pbs_pkg::PBS_DATA_RST;
			s_q.dq_oe <= 1'b0;
			s_q.mem <= s_d.mem;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops.
	assign o_dq = s_q.dq;
	assign o_dq_oe = s_q.dq_oe;
	assign o_wr_ready = wr_in_ready;
	assign o_selected = s_q.selected;
	assign o_sleeping = s_q.sleep;

	// Lane view kept for read-modify checks of the parity bit position.
	logic [pbs_pkg::PBS_LANE_W-1:0] lane0_view;
	assign lane0_view = lane_get(s_q.dq, 0);
endmodule

//--- bench/pbs_sram_ctrl_properties.sv
// Concurrent checks on the top ports of the burst memory control core.
// Assumes synchronous inputs and registered outputs, one clock domain.
`timescale 1ns/1ns
module pbs_sram_ctrl_properties (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_srst,
	// Watched inputs.
	input wire pbs_pkg::pbs_ctrl_t i_ctrl,
	input wire logic i_out_enable_n,
	input wire logic i_sleep_request,
	// Watched outputs.
	input wire logic o_dq_oe,
	input wire logic o_selected,
	input wire logic o_sleeping,
	input wire logic o_wr_ready
);
	logic run;
	logic ld;
	logic sel;
	// Decodes an address load, a full select and an awake edge.
	assign run = !o_sleeping && !i_sleep_request;
	assign ld = (!i_ctrl.processor_addr_strobe_n && !i_ctrl.chip_sel_primary_n)
		|| !i_ctrl.controller_addr_strobe_n;
	assign sel = !i_ctrl.chip_sel_primary_n && i_ctrl.chip_sel_high_active
		&& !i_ctrl.chip_sel_third_n;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	AST_SEL: assert property (run && ld && sel |=> o_selected)
		else $error("Selected load did not select.");
	AST_DESEL: assert property (run && ld && !sel |=> !o_selected && !o_dq_oe)
		else $error("Inactive select at load did not release.");
	AST_PROC_IGN: assert property (run && i_ctrl.chip_sel_primary_n
		&& !i_ctrl.processor_addr_strobe_n && i_ctrl.controller_addr_strobe_n
		|=> o_selected == $past(o_selected))
		else $error("Processor strobe acted with primary select high.");
	AST_CONT: assert property (run && !ld && o_selected |=> o_selected)
		else $error("Selects acted on a continuation edge.");
	AST_OE_OFF: assert property (i_out_enable_n |=> !o_dq_oe)
		else $error("Pins driven while output enable high.");
	AST_FIRST: assert property (run && ld && sel && !o_selected |=> !o_dq_oe)
		else $error("Pins driven in first cycle after deselect.");
	AST_SLEEP: assert property (i_sleep_request |=> o_sleeping)
		else $error("Sleep request not taken.");
	AST_WAKE: assert property (!i_sleep_request |=> !o_sleeping)
		else $error("Sleeping without request.");
	AST_SLP_DESEL: assert property (o_sleeping ##1 o_sleeping |-> !o_selected)
		else $error("Still selected while asleep.");
	AST_RST: assert property ($fell(i_srst) |-> o_wr_ready && !o_selected && !o_dq_oe)
		else $error("Wrong state after reset.");
	// Main scenarios.
	COV_BURST: cover property (o_dq_oe [*4]);
	COV_SLEEP: cover property (o_sleeping ##1 o_sleeping);
	COV_DESEL: cover property (run && ld && !sel);
endmodule

bind pbs_sram_ctrl pbs_sram_ctrl_properties chk_i (.i_clk(i_clk), .i_srst(i_srst),
	.i_ctrl(i_ctrl), .i_out_enable_n(i_out_enable_n), .i_sleep_request(i_sleep_request),
	.o_dq_oe(o_dq_oe), .o_selected(o_selected), .o_sleeping(o_sleeping),
	.o_wr_ready(o_wr_ready));

//--- bench/pbs_host_model.sv
// Host side of the data pins: drives write data and resolves the wire.
// Assumes the device output enable is high while the device drives.
`timescale 1ns/1ns
module pbs_host_model (
	// Clock.
	input wire logic i_clk,
	// Device and host drivers.
	input wire logic i_dev_oe,
	input wire logic [pbs_pkg::PBS_W-1:0] i_dev_dq,
	input wire logic i_drv_en,
	input wire logic [pbs_pkg::PBS_W-1:0] i_drv_dq,
	// Resolved wire and contention flag.
	output logic [pbs_pkg::PBS_W-1:0] o_wire,
	output logic o_clash
);
	logic [pbs_pkg::PBS_W-1:0] last_q = '0;
	// Keeps the last level so that an undriven wire can show its inverse.
	always_ff @(posedge i_clk) begin
		last_q <= o_wire;
	end
	// A floating wire shows the inverse of its level at the last edge.
	always_comb begin
		o_wire = i_dev_oe ? i_dev_dq : (i_drv_en ? i_drv_dq : ~last_q);
		o_clash = i_dev_oe && i_drv_en;
	end
endmodule

//--- bench/pbs_sram_ctrl_tb.sv
// Self-checking bench for the burst memory control core.
// Assumes the host model resolves the data wire at a 20 MHz clock.
`timescale 1ns/1ns
module pbs_sram_ctrl_tb;
	typedef logic [pbs_pkg::PBS_W-1:0] pbs_word_t;
	localparam pbs_pkg::pbs_ctrl_t IDLE = 12'h5FF;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	pbs_pkg::pbs_ctrl_t i_ctrl = IDLE;
	logic [5:0] i_addr = 6'h00;
	logic i_out_enable_n = 1'b1;
	logic strap = 1'b1;
	logic sleep = 1'b0;
	logic drv_en = 1'b0;
	pbs_word_t drv_dq = '0;
	pbs_word_t i_dq;
	pbs_word_t o_dq;
	pbs_word_t d;
	pbs_word_t shadow [64];
	logic o_dq_oe, o_wr_ready, o_selected, o_sleeping, clash;
	pbs_pkg::pbs_ctrl_t c;
	int fails = 0;
	int tests_run = 0;
	pbs_sram_ctrl #(.FIFO_DEPTH(4)) uut (.i_clk(i_clk), .i_srst(i_srst), .i_ctrl(i_ctrl),
		.i_addr(i_addr), .i_out_enable_n(i_out_enable_n), .i_dq(i_dq), .o_dq(o_dq),
		.o_dq_oe(o_dq_oe), .i_burst_order_strap(strap), .i_sleep_request(sleep),
		.o_wr_ready(o_wr_ready), .o_selected(o_selected), .o_sleeping(o_sleeping));
	pbs_host_model host (.i_clk(i_clk), .i_dev_oe(o_dq_oe), .i_dev_dq(o_dq),
		.i_drv_en(drv_en), .i_drv_dq(drv_dq), .o_wire(i_dq), .o_clash(clash));
	// Clock of 50 ns period.
	initial forever #25 i_clk = ~i_clk;
	// Compares one observed value with its expectation.
	task automatic chk(input pbs_word_t seen, input pbs_word_t exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Sets controls and address at a falling edge for the next rising edge.
	task automatic cyc(input pbs_pkg::pbs_ctrl_t k, input logic [5:0] a);
		@(negedge i_clk);
		i_ctrl = k;
		i_addr = a;
	endtask
	// Controller-strobe write; all-bytes write when gw is low, else byte write.
	task automatic wr(input logic [5:0] a, input pbs_word_t v, input logic gw,
		input logic [3:0] ln);
		pbs_pkg::pbs_ctrl_t k;
		k = IDLE;
		k.controller_addr_strobe_n = 1'b0;
		k.all_bytes_write_n = gw;
		k.byte_write_gate_n = !gw;
		k.byte_lane_select_n = ln;
		cyc(k, a);
		drv_en = 1'b1;
		drv_dq = v;
		for (int l = 0; l < 4; l++) begin
			if (!gw || !ln[l]) begin
				shadow[a][8*l +: 8] = v[8*l +: 8];
				shadow[a][32+l] = v[32+l];
			end
		end
		cyc(IDLE, a);
		drv_en = 1'b0;
		chk(o_wr_ready, 1'b1);
	endtask
	// Burst read of n beats; stepping continuation edges carry inactive selects.
	// The word accessed at one edge shows on the pins after the next edge.
	task automatic rd(input logic [5:0] a, input int n, input logic oen);
		pbs_pkg::pbs_ctrl_t k;
		logic [5:0] b;
		for (int i = 0; i < n + 2; i++) begin
			k = IDLE;
			if (i == 0) k.processor_addr_strobe_n = 1'b0;
			else if (i < n) begin
				k.burst_step_n = 1'b0;
				k.chip_sel_high_active = 1'b0;
				k.chip_sel_third_n = 1'b1;
			end
			cyc(k, a);
			i_out_enable_n = (i == 0) ? 1'b1 : oen;
			b = {a[5:2], strap ? a[1:0] ^ 2'(i - 2) : a[1:0] + 2'(i - 2)};
			if (i < 2) chk(o_dq_oe, 1'b0);
			else begin
				chk(o_dq_oe, !oen);
				chk(o_dq, shadow[b]);
			end
		end
		cyc(IDLE, a);
		i_out_enable_n = 1'b1;
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic conclude();
		$display("Counts: %0d compared, %0d mismatched.", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Any contention on the data wire is a mismatch.
	always @(posedge i_clk) begin
		if (clash === 1'b1) begin
			fails++;
			$display("[ERR] %0t data wire contention", $time);
		end
	end
	// Cuts a hang short.
	initial begin
		#100000;
		fails++;
		$display("[ERR] %0t watchdog expired", $time);
		conclude();
	end
	// Main sequence of tests.
	initial begin
		repeat (5) @(negedge i_clk);
		i_srst = 1'b0;
		chk(o_selected, 1'b0);
		for (int k = 0; k < 8; k++) wr(6'(k), 36'h912345670 + 36'(k) * 36'h101010101, 1'b0, 4'hF);
		wr(6'h02, 36'h0FFFFFFFF, 1'b1, 4'hA);
		repeat (3) cyc(IDLE, 6'h00);
		$display("Test writes done.");
		rd(6'h01, 4, 1'b0);
		rd(6'h06, 4, 1'b0);
		rd(6'h03, 1, 1'b1);
		$display("Test interleaved reads done.");
		i_srst = 1'b1;
		strap = 1'b0;
		repeat (2) cyc(IDLE, 6'h00);
		i_srst = 1'b0;
		chk(o_selected, 1'b0);
		rd(6'h05, 4, 1'b0);
		$display("Test linear reads done.");
		for (int s = 0; s < 3; s++) begin
			rd(6'h00, 1, 1'b0);
			c = IDLE;
			c.controller_addr_strobe_n = 1'b0;
			c[11-s] = ~c[11-s];
			cyc(c, 6'h00);
			i_out_enable_n = 1'b0;
			cyc(IDLE, 6'h00);
			i_out_enable_n = 1'b1;
			chk(o_selected, 1'b0);
			chk(o_dq_oe, 1'b0);
		end
		rd(6'h00, 1, 1'b0);
		c = IDLE;
		c.chip_sel_primary_n = 1'b1;
		c.processor_addr_strobe_n = 1'b0;
		cyc(c, 6'h3F);
		cyc(IDLE, 6'h00);
		chk(o_selected, 1'b1);
		$display("Test selects done.");
		c = IDLE;
		c.processor_addr_strobe_n = 1'b0;
		c.controller_addr_strobe_n = 1'b0;
		c.all_bytes_write_n = 1'b0;
		wr(6'h04, 36'h000000000, 1'b0, 4'hF);
		cyc(c, 6'h04);
		drv_en = 1'b1;
		drv_dq = 36'hFFFFFFFFF;
		cyc(IDLE, 6'h04);
		drv_en = 1'b0;
		repeat (3) cyc(IDLE, 6'h00);
		rd(6'h04, 1, 1'b0);
		// Processor-strobe write: the load edge reads, the next edge writes.
		c = IDLE;
		c.processor_addr_strobe_n = 1'b0;
		cyc(c, 6'h0A);
		c = IDLE;
		c.all_bytes_write_n = 1'b0;
		cyc(c, 6'h00);
		drv_en = 1'b1;
		drv_dq = 36'h5A5A5A5A5;
		shadow[10] = 36'h5A5A5A5A5;
		cyc(IDLE, 6'h00);
		drv_en = 1'b0;
		repeat (2) cyc(IDLE, 6'h00);
		rd(6'h0A, 1, 1'b0);
		$display("Test strobe priority done.");
		sleep = 1'b1;
		repeat (2) cyc(IDLE, 6'h00);
		chk(o_sleeping, 1'b1);
		chk(o_selected, 1'b0);
		d = shadow[7];
		wr(6'h07, 36'h000000000, 1'b0, 4'hF);
		shadow[7] = d;
		sleep = 1'b0;
		repeat (3) cyc(IDLE, 6'h00);
		chk(o_sleeping, 1'b0);
		rd(6'h07, 1, 1'b0);
		$display("Test sleep done.");
		conclude();
	end
endmodule
